// ### logic/cfg_slave_pkg.sv
/*
 * Shared constants and types for the two-wire configuration write slave.
 * Assumes a single 100 MHz system clock and a standard-mode host.
 */
package cfg_slave_pkg;
    localparam int          NUM_CFG_BYTES   = 6;
    localparam logic [7:0]  WRITE_ADDR      = 8'h00_D2;
    localparam logic [2:0]  LAST_BIT_IDX    = 3'h0_7;
    localparam logic [2:0]  LAST_DATA_IDX   = 3'h0_5;
    // Power-up defaults of configuration bytes 0..5
    localparam logic [7:0]  CFG_DEFAULT [NUM_CFG_BYTES] = '{
        8'h00_32, 8'h00_CF, 8'h00_FF, 8'h00_8F, 8'h00_81, 8'h00_FF
    };
    localparam int          SYS_CLK_MHZ     = 100;
    localparam int          LINK_MAX_KBPS   = 100;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_COUNT,
        ST_DATA,
        ST_IGNORE
    } slave_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } link_pins_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } link_events_t;
endpackage

// ### logic/link_sampler.sv
/*
 * Synchroniser and edge finder for the two-wire link pins.
 * Assumes scl and sda are asynchronous to i_clk_sys.
 */
`timescale 1ns/1ns
module link_sampler
    import cfg_slave_pkg::*;
(
    input  wire logic         i_clk_sys,
    input  wire logic         i_srst,
    input  wire link_pins_t   i_pins,
    output link_events_t      o_events
);
    link_pins_t meta;
    link_pins_t sync;
    link_pins_t prev;

    // First stage read only by the second stage
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            meta <= '1;
            sync <= '1;
            prev <= '1;
        end else begin
            meta <= i_pins;
            sync <= meta;
            prev <= sync;
        end
    end

    assign o_events.start    = prev.scl & sync.scl & prev.sda & ~sync.sda;
    assign o_events.stop     = prev.scl & sync.scl & ~prev.sda & sync.sda;
    assign o_events.scl_rise = ~prev.scl & sync.scl;
    assign o_events.scl_fall = prev.scl & ~sync.scl;
    assign o_events.sda      = sync.sda;
endmodule

// ### logic/clock_config_block_write_slave.sv
/*
 * Block-write receive slave that loads six configuration bytes.
 * Assumes a host on the two-wire link at standard mode; sda is open drain
 * and pulled up outside; scl is driven only by the host.
 */
`timescale 1ns/1ns
// Overview of operation
// [R01] Each transfer opens with a start condition, which resets the byte sequence.
// [R02] The device acknowledges the write address D2 hex after a start.
// [R03] The next byte is a command code of any value and is acknowledged.
// [R04] The following byte count of any value is acknowledged before data.
// [R05] Data bytes are acknowledged one by one and land at index 0 up to 5.
// [R06] A stop condition ends the transfer and returns the device to idle.
// [R07] Command-code and byte-count values are thrown away, never stored.
// [R08] Data loads in ascending order until stop; untouched bytes keep their values.
// [R09] The host clocks the link at 100 kbit/s or slower.
// [R10] On reset every configuration byte takes its default value.
// [R11] A foreign address gets no acknowledge and the rest is ignored until the next start.
module clock_config_block_write_slave
    import cfg_slave_pkg::*;
(
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_srst,
    input  wire logic                      i_scl,
    input  wire logic                      i_sda,
    output logic                           o_sda,
    output logic                           o_sda_oe,
    output logic [NUM_CFG_BYTES*8-1:0]     o_cfg,
    output logic                           o_cfg_wr,
    output logic [2:0]                     o_cfg_idx
);
    link_pins_t     pins;
    link_events_t   ev;
    logic           ack_drive_on;
    slave_state_t   state;
    slave_state_t   next_state;
    logic [7:0]     shreg;
    logic [2:0]     bit_cnt;
    logic           ack_phase;
    logic           ack_drive;
    logic [2:0]     data_idx;
    logic           data_full;
    logic [7:0]     cfg [NUM_CFG_BYTES];

    // Clock first, data second, as the pin struct orders them
    assign pins = {i_scl, i_sda};

    link_sampler u_sampler (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .i_pins    (pins),
        .o_events  (ev)
    );

    wire byte_done  = ev.scl_rise & ~ack_phase & (bit_cnt == LAST_BIT_IDX);
    wire [7:0] rx_byte = {shreg[6:0], ev.sda};
    wire addr_hit   = (rx_byte == WRITE_ADDR);                        // [R02]
    wire store_data = byte_done & (state == ST_DATA) & ~data_full;   // [R05] [R07]

    always_comb begin
        next_state = state;
        if (ev.start) begin
            next_state = ST_ADDR;                                     // [R01]
        end else if (ev.stop) begin
            next_state = ST_IDLE;                                     // [R06] [R08]
        end else if (byte_done) begin
            unique case (state)
                ST_ADDR:  next_state = addr_hit ? ST_CMD : ST_IGNORE; // [R11]
                ST_CMD:   next_state = ST_COUNT;                      // [R03]
                ST_COUNT: next_state = ST_DATA;                       // [R04]
                default:  next_state = state;
            endcase
        end
    end

    // Acknowledge for every byte the state accepts
    wire ack_wanted = (state == ST_ADDR) ? addr_hit :
                      (state == ST_CMD) | (state == ST_COUNT) | ((state == ST_DATA) & ~data_full);

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst | ev.start) begin
            bit_cnt   <= '0;
            ack_phase <= 1'b0;
            ack_drive <= 1'b0;
            shreg     <= '0;
        end else if (ev.scl_rise & ~ack_phase) begin
            shreg   <= rx_byte;
            bit_cnt <= bit_cnt + 3'h0_1;
            if (byte_done) begin
                ack_phase <= 1'b1;
                ack_drive <= ack_wanted & (state != ST_IGNORE) & (state != ST_IDLE); // [R11]
            end
        end else if (ev.scl_fall & ack_phase & (bit_cnt == '0) & ~ack_drive_on) begin
            ack_phase <= 1'b1;
        end else if (ev.scl_fall & ack_drive_on) begin
            ack_phase <= 1'b0;
            ack_drive <= 1'b0;
        end else if (ev.scl_rise & ack_phase) begin
            ack_phase <= 1'b0;
        end
    end

    // Acknowledge pulled low from the fall after the eighth bit to the next fall
    always_ff @(posedge i_clk_sys) begin
        if (i_srst | ev.start | ev.stop) begin
            ack_drive_on <= 1'b0;
        end else if (ev.scl_fall & ack_phase & ~ack_drive_on) begin
            ack_drive_on <= ack_drive;                                // [R02] [R03] [R04] [R05]
        end else if (ev.scl_fall & ack_drive_on) begin
            ack_drive_on <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst | ev.start) begin
            data_idx  <= '0;                                          // [R08]
            data_full <= 1'b0;
        end else if (store_data) begin
            data_idx  <= data_idx + 3'h0_1;
            data_full <= (data_idx == LAST_DATA_IDX);                 // [R05]
        end
    end

    // Byte store; defaults on reset, only data bytes written
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            for (int i = 0; i < NUM_CFG_BYTES; i++) begin
                cfg[i] <= CFG_DEFAULT[i];                             // [R10]
            end
            o_cfg_wr  <= 1'b0;
            o_cfg_idx <= '0;
        end else begin
            o_cfg_wr <= store_data;
            if (store_data) begin
                cfg[data_idx] <= rx_byte;                             // [R05] [R08]
                o_cfg_idx     <= data_idx;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_CFG_BYTES; i++) begin
            o_cfg[i*8 +: 8] = cfg[i];
        end
    end

    // Open drain: only ever drive low
    assign o_sda    = 1'b0;
    assign o_sda_oe = ack_drive_on;
endmodule

// ### sim/cfg_host_model.sv
/* Behavioural two-wire host that opens, sends and closes transfers.
   Assumes the bench resolves sda as an open-drain wire with pull-up. */
`timescale 1ns/1ns
module cfg_host_model (
    output logic      o_scl,
    output logic      o_sda_low,
    input  wire logic i_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic start_cond();
        o_sda_low = 1'b0;
        #31 o_scl = 1'b1;
        #62 o_sda_low = 1'b1;
        #62 o_scl = 1'b0;
        #32;
    endtask
    task automatic stop_cond();
        o_sda_low = 1'b1;
        #31 o_scl = 1'b1;
        #62 o_sda_low = 1'b0;
        #125;
    endtask
    // Shortened 125 ns link period to keep runs short; sda only moves while scl is low
    // Slave logic only needs four system clocks per scl phase, not the real rate limit
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            o_sda_low = !b[i];
            #31 o_scl = 1'b1;
            #62 o_scl = 1'b0;
            #32;
        end
        o_sda_low = 1'b0;
        #31 o_scl = 1'b1;
        #31 ack = !i_sda;
        #31 o_scl = 1'b0;
        #32;
    endtask
endmodule

// ### sim/clock_config_block_write_slave_monitor.sv
/* Port checks for the configuration write slave.
   Bound into every slave instance; one clock domain. */
`timescale 1ns/1ns
module clock_config_block_write_slave_monitor
    import cfg_slave_pkg::*;
(
    input wire logic                       i_clk_sys,
    input wire logic                       i_srst,
    input wire logic                       i_scl,
    input wire logic                       i_sda,
    input wire logic                       o_sda,
    input wire logic                       o_sda_oe,
    input wire logic [NUM_CFG_BYTES*8-1:0] o_cfg,
    input wire logic                       o_cfg_wr,
    input wire logic [2:0]                 o_cfg_idx
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    wire logic [47:0] dflt = {CFG_DEFAULT[5], CFG_DEFAULT[4], CFG_DEFAULT[3],
                              CFG_DEFAULT[2], CFG_DEFAULT[1], CFG_DEFAULT[0]};
    AST_RST: assert property ($fell(i_srst) |-> o_cfg == dflt && !o_sda_oe)
        else $error("bad reset state");
    AST_OD: assert property (o_sda == 1'b0)
        else $error("sda drive not low");
    AST_WR: assert property (o_cfg_wr |-> o_cfg_idx <= 3'h5 ##1 !o_cfg_wr)
        else $error("bad store pulse");
    AST_IDX: assert property (o_cfg_wr && o_cfg_idx != 3'h0 |-> o_cfg_idx == $past(o_cfg_idx) + 3'h1)
        else $error("store out of order");
    AST_CHG: assert property ($changed(o_cfg) |-> o_cfg_wr)
        else $error("config changed without store");
    AST_LEN: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8])
        else $error("ack too short");
    AST_LOW: assert property ($rose(o_sda_oe) |-> !i_scl)
        else $error("ack raised with scl high");
    AST_ACK: assert property (o_cfg_wr |-> !o_sda_oe ##[1:15] o_sda_oe)
        else $error("stored byte not acked");
    CV_LAST: cover property (o_cfg_wr && o_cfg_idx == 3'h5);
    CV_ACK: cover property ($rose(o_sda_oe));
    CV_RST: cover property ($fell(i_srst));
endmodule
bind clock_config_block_write_slave clock_config_block_write_slave_monitor i_mon (.i_clk_sys, .i_srst,
    .i_scl, .i_sda, .o_sda, .o_sda_oe, .o_cfg, .o_cfg_wr, .o_cfg_idx);

// ### sim/clock_config_block_write_slave_test.sv
/* Self-checking bench for the configuration write slave.
   Host model drives the link; sda is resolved with a pull-up. */
`timescale 1ns/1ns
module clock_config_block_write_slave_test;
    import cfg_slave_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        scl, host_low, oe, wr;
    logic [2:0]  idx;
    logic [47:0] cfg;
    logic [7:0]  exp_cfg [6];
    int          fail_count = 0;
    int          tests_run = 0;
    wire logic   sda = !(host_low || oe);
    initial begin
        forever #5 clk = !clk;
    end
    cfg_host_model i_host (.o_scl(scl), .o_sda_low(host_low), .i_sda(sda));
    clock_config_block_write_slave i_dut (.i_clk_sys(clk), .i_srst(srst), .i_scl(scl), .i_sda(sda),
        .o_sda(), .o_sda_oe(oe), .o_cfg(cfg), .o_cfg_wr(wr), .o_cfg_idx(idx));
    task automatic chk(input logic [47:0] seen, input logic [47:0] want);
        tests_run++;
        if (seen !== want) begin
            fail_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    function automatic logic [47:0] packed_exp();
        for (int i = 0; i < 6; i++) packed_exp[8*i +: 8] = exp_cfg[i];
    endfunction
    task automatic do_reset();
        @(posedge clk) srst <= 1'b1;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        foreach (exp_cfg[i]) exp_cfg[i] = CFG_DEFAULT[i];
        chk(cfg, packed_exp());
        chk({idx, wr, oe}, 5'h0);
        $display("reset test done");
    endtask
    // Bytes at position acked and later must go unanswered
    task automatic xfer(input logic [7:0] addr, input int n, input int acked);
        logic ack;
        i_host.start_cond();
        for (int k = 0; k < n; k++) begin
            i_host.send_byte(k == 0 ? addr : 8'h0A * k[7:0], ack);
            chk(ack, k < acked);
            if (k >= 3 && k < acked) exp_cfg[k-3] = 8'h0A * k[7:0];
        end
        i_host.stop_cond();
        chk(cfg, packed_exp());
    endtask
    task automatic t_full();
        xfer(WRITE_ADDR, 10, 9);
        chk(idx, 3'h5);
        $display("full write test done");
    endtask
    task automatic t_partial();
        xfer(WRITE_ADDR, 3, 3);
        xfer(WRITE_ADDR, 5, 5);
        $display("partial write test done");
    endtask
    task automatic t_foreign();
        xfer(8'hD3, 5, 0);
        $display("foreign address test done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        do_reset();
        t_full();
        t_partial();
        t_foreign();
        do_reset();
        tally_and_finish();
    end
    initial begin
        #200000;
        fail_count++;
        tally_and_finish();
    end
endmodule
